// >>> rtl/display_driver_regs.svh
`ifndef DISPLAY_DRIVER_REGS_SVH
`define DISPLAY_DRIVER_REGS_SVH

// Number of channels and shift stages
`define CHAN_COUNT 32
// Power-on value of register and latch (block has no documented reset)
`define SHIFT_RESET_VALUE 32'h00000000
`define LATCH_RESET_VALUE 32'h00000000

`endif

// >>> rtl/display_driver_pkg.sv
`default_nettype none
package display_driver_pkg;
  `include "display_driver_regs.svh"
  typedef logic [`CHAN_COUNT-1:0] chan_word_t;
endpackage
`default_nettype wire

// >>> rtl/pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels and the shift-clock rising edge
interface pin_sync_if;
  logic data;
  logic latch_load_enable;
  logic output_strobe;
  logic shift_rise;
  modport src (output data, latch_load_enable, output_strobe, shift_rise);
  modport dst (input data, latch_load_enable, output_strobe, shift_rise);
endinterface
`default_nettype wire

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchronisers for all pins plus edge finder on the shift clock
module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Raw pins
  input wire logic shift_clock_i,
  input wire logic serial_data_i,
  input wire logic latch_load_enable_i,
  input wire logic output_strobe_i,
  // Synchronised side
  pin_sync_if.src sync
);
  logic [3:0] meta;
  logic [3:0] stable;
  logic clk_prev;
  logic [3:0] next_meta;
  logic [3:0] next_stable;
  logic next_clk_prev;

  // Next values: first stage feeds only the second stage
  always_comb begin
    next_meta = {shift_clock_i, serial_data_i, latch_load_enable_i,
                 output_strobe_i};
    next_stable = meta;
    next_clk_prev = stable[3];
  end

  // Registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= 4'h0;
      stable <= 4'h0;
      clk_prev <= 1'b0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      clk_prev <= next_clk_prev;
    end
  end

  // Data passes the same two flops as the clock, so it is taken in the
  // cycle the edge is found; the host must hold it well past the edge.
  assign sync.data = stable[2];
  assign sync.latch_load_enable = stable[1];
  assign sync.output_strobe = stable[0];
  assign sync.shift_rise = stable[3] & ~clk_prev;
endmodule
`default_nettype wire

// >>> rtl/display_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "display_driver_regs.svh"

module display_driver
  import display_driver_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host pins
  input wire logic shift_clock_i,
  input wire logic serial_data_i,
  input wire logic latch_load_enable_i,
  input wire logic output_strobe_i,
  // Outputs
  output logic serial_data_o,
  output logic [`CHAN_COUNT-1:0] high_voltage_output_o
);
  // Synchronised pin levels and the found shift-clock edge
  pin_sync_if sync ();

  // Register, latch and the values they take at the next edge
  chan_word_t shift_reg;
  chan_word_t latch_reg;
  chan_word_t next_shift_reg;
  chan_word_t next_latch_reg;
  chan_word_t next_outputs;
  logic next_serial;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  pin_sync u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .shift_clock_i(shift_clock_i),
    .serial_data_i(serial_data_i),
    .latch_load_enable_i(latch_load_enable_i),
    .output_strobe_i(output_strobe_i),
    .sync(sync)
  );

  // ------------------------------------------------------------------
  // Shift register and latch
  // ------------------------------------------------------------------
  // Shift on each found rising edge, stage 0 receives data
  always_comb begin
    next_shift_reg = shift_reg;
    if (sync.shift_rise) begin
      next_shift_reg = {shift_reg[`CHAN_COUNT-2:0], sync.data};
    end
    next_serial = next_shift_reg[`CHAN_COUNT-1];
  end

  // Latch per channel: transparent to the register while enabled
  genvar ch;
  generate
    for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
      always_comb begin
        if (sync.latch_load_enable) begin
          next_latch_reg[ch] = shift_reg[ch];
        end else begin
          next_latch_reg[ch] = latch_reg[ch];
        end
        // Strobe blanks every channel, otherwise show the latch
        if (sync.output_strobe) begin
          next_outputs[ch] = 1'b0;
        end else begin
          next_outputs[ch] = next_latch_reg[ch];
        end
      end
    end
  endgenerate

  // Registers; the latch is a clocked copy, so it lags by one cycle,
  // a trade for a single clock that the slow pins never notice
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= `SHIFT_RESET_VALUE;
      latch_reg <= `LATCH_RESET_VALUE;
      serial_data_o <= 1'b0;
      high_voltage_output_o <= '0;
    end else begin
      shift_reg <= next_shift_reg;
      latch_reg <= next_latch_reg;
      serial_data_o <= next_serial;
      high_voltage_output_o <= next_outputs;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Steps of the pin protocol as the core sees them behind the
  // synchronisers; each shift-clock rise shows as a one-cycle pulse,
  // and ten of the fifteen properties below are built from these steps
  sequence s_rise;
    sync.shift_rise;
  endsequence

  sequence s_quiet;
    !sync.shift_rise;
  endsequence

  sequence s_shown;
    !sync.output_strobe;
  endsequence

  sequence s_open_shown;
    sync.latch_load_enable && !sync.output_strobe;
  endsequence

  sequence s_closed_shown;
    !sync.latch_load_enable && !sync.output_strobe;
  endsequence

  sequence s_blank_open;
    sync.output_strobe && sync.latch_load_enable;
  endsequence

  // Two steps: outputs already shown, then the latch closes
  sequence s_shown_then_closed;
    s_shown ##1 s_closed_shown;
  endsequence

  // Shift register: one step per found edge, none without one
  a_shift_takes_data: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_rise |=> shift_reg[0] == $past(sync.data))
    else $error("stage one did not take the data pin");

  a_shift_moves_word: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_rise |=> shift_reg[`CHAN_COUNT-1:1] ==
      $past(shift_reg[`CHAN_COUNT-2:0]))
    else $error("register did not move by one");

  a_shift_holds: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_quiet |=> $stable(shift_reg))
    else $error("register moved without an edge");

  // Each pin edge must count once, or a frame would over-shift
  a_rise_single: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_rise |=> s_quiet)
    else $error("one pin edge shifted twice");

  // Serial output for cascading: always the last stage, so it moves
  // only with a shift and then shows what the stage before held
  a_serial_tracks_last: assert property (
    @(posedge clk_i) disable iff (reset_i)
    serial_data_o == shift_reg[`CHAN_COUNT-1])
    else $error("serial output not last stage");

  a_serial_holds: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_quiet |=> $stable(serial_data_o))
    else $error("serial output moved without an edge");

  a_serial_next_stage: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_rise |=> serial_data_o == $past(shift_reg[`CHAN_COUNT-2]))
    else $error("serial output skipped a stage");

  // Latch: open copies the register, closed keeps the last word, and
  // the outputs see either one at the same edge while the strobe is low
  a_latch_follows: assert property (
    @(posedge clk_i) disable iff (reset_i)
    sync.latch_load_enable |=> latch_reg == $past(shift_reg))
    else $error("latch not transparent");

  a_latch_holds: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !sync.latch_load_enable |=> $stable(latch_reg))
    else $error("latch changed while closed");

  a_open_to_pins: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_open_shown |=> high_voltage_output_o == $past(shift_reg))
    else $error("open latch did not reach the outputs");

  a_closed_pins_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_shown_then_closed |=> $stable(high_voltage_output_o))
    else $error("outputs moved while the latch was closed");

  // Output stage: the strobe wins over an open latch, otherwise the
  // outputs show the latch word
  a_strobe_blanks: assert property (
    @(posedge clk_i) disable iff (reset_i)
    sync.output_strobe |=> high_voltage_output_o == '0)
    else $error("outputs not low under strobe");

  a_blank_beats_open: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_blank_open |=> high_voltage_output_o == '0)
    else $error("open latch leaked through the strobe");

  a_outputs_follow: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !sync.output_strobe |=> high_voltage_output_o == latch_reg)
    else $error("outputs do not follow latch");

  // Per channel: each output is fed only from its own stage
  for (genvar n = 0; n < `CHAN_COUNT; n++) begin : g_chan_check
    a_chan_own_stage: assert property (
      @(posedge clk_i) disable iff (reset_i)
      s_open_shown |=> high_voltage_output_o[n] == $past(shift_reg[n]))
      else $error("channel not fed from its own stage");
  end
endmodule
`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller: every pin moves on a falling clk edge
module host_model
  import display_driver_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Pins toward the driver
  output logic shift_clock_o,
  output logic serial_data_o,
  output logic latch_load_enable_o,
  output logic output_strobe_o
);
  // Shift clock stands low outside frames
  initial begin
    shift_clock_o = 1'b0;
    serial_data_o = 1'b0;
    latch_load_enable_o = 1'b0;
    output_strobe_o = 1'b0;
  end
  // 400 ns period; data moves on the falling edge for long setup and hold
  task automatic send_word(input chan_word_t w);
    for (int i = $bits(chan_word_t) - 1; i >= 0; i--) begin
      serial_data_o = w[i];
      repeat (4) @(negedge clk_i);
      shift_clock_o = 1'b1;
      repeat (4) @(negedge clk_i);
      shift_clock_o = 1'b0;
    end
    @(negedge clk_i);
    serial_data_o = ~w[0]; // Released line must not show the stale bit
  endtask
  // Control levels, then wait past the answer latency
  task automatic set_ctrl(input logic le, input logic str);
    latch_load_enable_o = le;
    output_strobe_o = str;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
  import display_driver_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wire logic sck, sdi, le, str, sdo;
  wire chan_word_t hvo;
  int failures = 0;
  int tests_run = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  host_model u_host_model(.clk_i(clk), .shift_clock_o(sck),
    .serial_data_o(sdi), .latch_load_enable_o(le), .output_strobe_o(str));
  display_driver u_display_driver(.clk_i(clk), .reset_i(reset),
    .shift_clock_i(sck), .serial_data_i(sdi), .latch_load_enable_i(le),
    .output_strobe_i(str), .serial_data_o(sdo), .high_voltage_output_o(hvo));
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_load();
    u_host_model.send_word(32'hA5C30F81);
    repeat (6) @(negedge clk);
    `CHK(hvo, 32'h00000000)
    `CHK(sdo, 1'b1)
    u_host_model.set_ctrl(1'b1, 1'b0);
    `CHK(hvo, 32'hA5C30F81)
    u_host_model.set_ctrl(1'b0, 1'b0);
  endtask
  // Data pin flips after the frame with no shift edge
  task automatic t_hold();
    u_host_model.send_word(32'h5A3CF07E);
    repeat (6) @(negedge clk);
    `CHK(hvo, 32'hA5C30F81)
    `CHK(sdo, 1'b0)
    u_host_model.set_ctrl(1'b1, 1'b0);
    `CHK(hvo, 32'h5A3CF07E)
  endtask
  // Strobe overrides an open latch, then releases it
  task automatic t_strobe();
    u_host_model.set_ctrl(1'b1, 1'b1);
    `CHK(hvo, 32'h00000000)
    u_host_model.set_ctrl(1'b0, 1'b1);
    u_host_model.set_ctrl(1'b0, 1'b0);
    `CHK(hvo, 32'h5A3CF07E)
  endtask
  task automatic summarize();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_load();
    t_hold();
    t_strobe();
    summarize();
  end
  // Watchdog: the run needs about 30 us
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
